// ==== hdl/dual_mode_serial_host_port.v ====
// dual mode serial host port: spi mode 0 slave or i2c slave, strap selected,
// plus interrupt output, power-down input and backlight pwm
// assumes pins are asynchronous to clk and are synchronised here; byte data
// and interrupt request come from the graphics engine on the same clock
`timescale 1ns/100ps
`include "serial_host_port_regs.vh"

module dual_mode_serial_host_port #(
   parameter ACC_W  = 16,
   parameter DUTY_W = 7
) (
   input  wire              clk,
   input  wire              rst,
   input  wire              sck_scl_pin,
   input  wire              mosi_pin,
   input  wire              cs_n_pin,
   input  wire              miso_sda_in,
   output reg               miso_sda_out,
   output reg               miso_sda_oe,
   input  wire              mode_strap,
   input  wire              powerdown_in_n,
   output reg               int_n,
   output wire              backlight_en,
   input  wire              irq_request,
   input  wire [ACC_W-1:0]  pwm_freq,
   input  wire [DUTY_W:0]   pwm_duty,
   input  wire [7:0]        tx_data,
   output reg               tx_taken,
   output reg  [7:0]        rx_data,
   output reg               rx_valid,
   output reg               frame_start,
   output reg               frame_end,
   output reg               i2c_read,
   output reg               i2c_mode,
   output reg               powered_down
);

   // two-stage synchronisers for every pin, then one more stage for edges
   reg  [5:0]  sync1;
   reg  [5:0]  sync2;
   reg         scl_q;
   reg         sda_q;
   reg         cs_q;
   reg         mode_taken;
   reg  [2:0]  state;
   reg  [3:0]  bit_cnt;
   reg  [7:0]  rx_sh;
   reg  [7:0]  tx_sh;
   reg         acked;
   wire        sck;
   wire        mosi;
   wire        cs_n;
   wire        sda;
   wire        strap;
   wire        awake;
   wire        rise;
   wire        fall;
   wire        start_cond;
   wire        stop_cond;
   wire [6:0]  own_addr;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1 <= 6'h00;
         sync2 <= 6'h00;
      end else begin
         sync1 <= {powerdown_in_n, mode_strap, miso_sda_in, cs_n_pin, mosi_pin, sck_scl_pin};
         sync2 <= sync1;
      end
   end

   assign sck   = sync2[0];
   assign mosi  = sync2[1];
   assign cs_n  = sync2[2];
   assign sda   = sync2[3];
   assign strap = sync2[4];
   assign awake = sync2[5];

   // edge detection on the synchronised link clock and sda
   assign rise       = sck & ~scl_q;
   assign fall       = ~sck & scl_q;
   assign start_cond = i2c_mode & sck & scl_q & sda_q & ~sda;
   assign stop_cond  = i2c_mode & sck & scl_q & ~sda_q & sda;

   // straps double as address bits in i2c mode, never as data or framing
   assign own_addr = {`SHP_ADDR_HI, cs_n, mosi};

   // strap caught once after reset release, after it has crossed the synchroniser;
   // an open strap reads low and gives spi
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_taken <= 1'b0;
         i2c_mode   <= 1'b0;
      end else if (!mode_taken && awake) begin
         mode_taken <= 1'b1;
         i2c_mode   <= (strap == `SHP_MODE_I2C);
      end
   end

   // interrupt and power-down status; a sleeping block raises no interrupt
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         int_n        <= 1'b1;
         powered_down <= 1'b1;
      end else begin
         int_n        <= ~(irq_request & awake);
         powered_down <= ~awake;
      end
   end

   backlight_pwm #(
      .ACC_W  (ACC_W),
      .DUTY_W (DUTY_W)
   ) u_pwm (
      .clk  (clk),
      .rst  (rst),
      .run  (awake),
      .freq (pwm_freq),
      .duty (pwm_duty),
      .pwm  (backlight_en)
   );

   // link engine: spi mode 0 or i2c slave, held idle in power-down
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_q        <= 1'b1;
         sda_q        <= 1'b1;
         cs_q         <= 1'b1;
         state        <= `SHP_ST_IDLE;
         bit_cnt      <= 4'h0;
         rx_sh        <= 8'h00;
         tx_sh        <= 8'h00;
         acked        <= 1'b0;
         miso_sda_out <= 1'b0;
         miso_sda_oe  <= 1'b0;
         rx_data      <= 8'h00;
         rx_valid     <= 1'b0;
         tx_taken     <= 1'b0;
         frame_start  <= 1'b0;
         frame_end    <= 1'b0;
         i2c_read     <= 1'b0;
      end else begin
         scl_q       <= sck;
         sda_q       <= sda;
         cs_q        <= cs_n;
         rx_valid    <= 1'b0;
         tx_taken    <= 1'b0;
         frame_start <= 1'b0;
         frame_end   <= 1'b0;
         if (!awake || !mode_taken) begin
            // power-down releases the data pin and drops any transfer
            state       <= `SHP_ST_IDLE;
            bit_cnt     <= 4'h0;
            miso_sda_oe <= 1'b0;
         end else if (!i2c_mode) begin
            // spi: chip select frames, sample on rise, shift on fall
            if (cs_n) begin
               miso_sda_oe <= 1'b0;
               bit_cnt     <= 4'h0;
               if (!cs_q)
                  frame_end <= 1'b1;
            end else if (cs_q) begin
               frame_start  <= 1'b1;
               bit_cnt      <= 4'h0;
               tx_sh        <= tx_data;
               tx_taken     <= 1'b1;
               miso_sda_out <= tx_data[7];
               miso_sda_oe  <= 1'b1;
            end else if (rise) begin
               rx_sh   <= {rx_sh[6:0], mosi};
               bit_cnt <= {1'b0, bit_cnt[2:0] + 3'h1};
               if (bit_cnt[2:0] == 3'h7) begin
                  rx_data  <= {rx_sh[6:0], mosi};
                  rx_valid <= 1'b1;
               end
            end else if (fall) begin
               // a wrapped count means the byte ended: fetch the next one
               if (bit_cnt[2:0] == 3'h0) begin
                  tx_sh        <= tx_data;
                  tx_taken     <= 1'b1;
                  miso_sda_out <= tx_data[7];
               end else begin
                  tx_sh        <= {tx_sh[6:0], 1'b0};
                  miso_sda_out <= tx_sh[6];
               end
            end
         end else begin
            // i2c: only ever pulls sda low, the pin pull-up gives the high
            miso_sda_out <= 1'b0;
            if (start_cond) begin
               state       <= `SHP_ST_ADDR;
               bit_cnt     <= 4'h0;
               miso_sda_oe <= 1'b0;
               frame_start <= 1'b1;
            end else if (stop_cond) begin
               state       <= `SHP_ST_IDLE;
               miso_sda_oe <= 1'b0;
               if (state != `SHP_ST_IDLE && state != `SHP_ST_WAIT)
                  frame_end <= 1'b1;
            end else if (rise) begin
               if (state == `SHP_ST_ADDR || state == `SHP_ST_WR) begin
                  rx_sh   <= {rx_sh[6:0], sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (state == `SHP_ST_RD) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (state == `SHP_ST_ACK_R) begin
                  acked <= ~sda;
               end
            end else if (fall) begin
               case (state)
                  `SHP_ST_ADDR: begin
                     if (bit_cnt == `SHP_BYTE_BITS) begin
                        // master codes for high speed never match, so stay silent
                        if (rx_sh[7:1] == own_addr) begin
                           miso_sda_oe <= 1'b1;
                           i2c_read    <= rx_sh[0];
                           state       <= `SHP_ST_ACK_A;
                        end else begin
                           state <= `SHP_ST_WAIT;
                        end
                     end
                  end
                  `SHP_ST_ACK_A, `SHP_ST_ACK_R: begin
                     bit_cnt <= 4'h0;
                     if ((state == `SHP_ST_ACK_A && i2c_read) || (state == `SHP_ST_ACK_R && acked)) begin
                        tx_sh       <= {tx_data[6:0], 1'b0};
                        tx_taken    <= 1'b1;
                        miso_sda_oe <= ~tx_data[7];
                        state       <= `SHP_ST_RD;
                     end else begin
                        miso_sda_oe <= 1'b0;
                        state       <= (state == `SHP_ST_ACK_A) ? `SHP_ST_WR : `SHP_ST_WAIT;
                     end
                  end
                  `SHP_ST_WR: begin
                     if (bit_cnt == `SHP_BYTE_BITS) begin
                        rx_data     <= rx_sh;
                        rx_valid    <= 1'b1;
                        miso_sda_oe <= 1'b1;
                        state       <= `SHP_ST_ACK_W;
                     end
                  end
                  `SHP_ST_ACK_W: begin
                     miso_sda_oe <= 1'b0;
                     bit_cnt     <= 4'h0;
                     state       <= `SHP_ST_WR;
                  end
                  `SHP_ST_RD: begin
                     if (bit_cnt == `SHP_BYTE_BITS) begin
                        miso_sda_oe <= 1'b0;
                        state       <= `SHP_ST_ACK_R;
                     end else begin
                        miso_sda_oe <= ~tx_sh[7];
                        tx_sh       <= {tx_sh[6:0], 1'b0};
                     end
                  end
                  default: begin
                     miso_sda_oe <= 1'b0;
                  end
               endcase
            end
         end
      end
   end

   // rate ceilings hold only while each sck/scl phase lasts at least two clk
   // periods after synchronisation; the bench link at 160 ns period does

endmodule

// ==== common/serial_host_port_regs.vh ====
// constants for the dual mode serial host port and its backlight pwm
// assumes a 50 MHz system clock; included by bare name
`ifndef SERIAL_HOST_PORT_REGS_VH
`define SERIAL_HOST_PORT_REGS_VH

// system clock and link rate ceilings, in hertz
`define SHP_CLK_HZ        50000000
`define SHP_SPI_MAX_HZ    30000000
`define SHP_I2C_MAX_HZ    3400000

// interface select strap levels
`define SHP_MODE_SPI      1'b0
`define SHP_MODE_I2C      1'b1

// fixed upper five bits of the 7-bit slave address (binary 01000)
`define SHP_ADDR_HI       5'h08
`define SHP_ADDR_HI_W     5

// i2c slave states
`define SHP_ST_IDLE       3'h0
`define SHP_ST_ADDR       3'h1
`define SHP_ST_ACK_A      3'h2
`define SHP_ST_WR         3'h3
`define SHP_ST_ACK_W      3'h4
`define SHP_ST_RD         3'h5
`define SHP_ST_ACK_R      3'h6
`define SHP_ST_WAIT       3'h7

// bits per byte on the link
`define SHP_BYTE_BITS     4'h8

// pwm reset values
`define SHP_PWM_PHASE_RST 16'h0000

`endif

// ==== hdl/backlight_pwm.v ====
// backlight pwm generator: phase accumulator sets frequency, compare sets duty
// assumes freq and duty come from controller registers on the same clock
`timescale 1ns/100ps
`include "serial_host_port_regs.vh"

module backlight_pwm #(
   parameter ACC_W  = 16,
   parameter DUTY_W = 7
) (
   input  wire              clk,
   input  wire              rst,
   input  wire              run,
   input  wire [ACC_W-1:0]  freq,
   input  wire [DUTY_W:0]   duty,
   output reg               pwm
);

   reg  [ACC_W-1:0]  phase;
   wire [DUTY_W:0]   phase_top;

   // the top phase bits form the ramp compared against duty
   assign phase_top = {1'b0, phase[ACC_W-1 -: DUTY_W]};

   // output rate is freq * clk / 2^ACC_W; duty at or above full scale holds high
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         phase <= `SHP_PWM_PHASE_RST;
         pwm   <= 1'b0;
      end else if (!run) begin
         phase <= `SHP_PWM_PHASE_RST;
         pwm   <= 1'b0;
      end else begin
         phase <= phase + freq;
         pwm   <= (phase_top < duty);
      end
   end

endmodule

// ==== tb/serial_port_checker_assertions.sv ====
// assertions on the serial host port interrupt, pwm, pin drive and frame pulses
// assumes binding to the top module, one clock domain with async reset
`timescale 1ns/100ps
module serial_port_checker #(
   parameter DUTY_W = 7
) (
   input wire            clk,
   input wire            rst,
   input wire            cs_n_pin,
   input wire            irq_request,
   input wire [DUTY_W:0] pwm_duty,
   input wire            miso_sda_out,
   input wire            miso_sda_oe,
   input wire            int_n,
   input wire            backlight_en,
   input wire            rx_valid,
   input wire            frame_start,
   input wire            i2c_mode,
   input wire            powered_down
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // settled awake or asleep spans, long enough for the pin synchronisers
   sequence s_awake;
      !powered_down[*6];
   endsequence
   sequence s_asleep;
      powered_down[*4];
   endsequence
   property p_int_low;
      (irq_request && !powered_down)[*2] |-> !int_n;
   endproperty
   a_int_low: assert property (p_int_low) else $error("int_n high while request pending");
   property p_int_idle;
      !irq_request[*2] |-> int_n;
   endproperty
   a_int_idle: assert property (p_int_idle) else $error("int_n low without request");
   property p_duty_off;
      (pwm_duty == 0)[*3] |-> !backlight_en;
   endproperty
   a_duty_off: assert property (p_duty_off) else $error("backlight on at zero duty");
   property p_duty_full;
      (pwm_duty[DUTY_W] && !powered_down)[*3] |-> backlight_en;
   endproperty
   a_duty_full: assert property (p_duty_full) else $error("backlight off at full duty");
   property p_mode_hold;
      s_awake |=> $stable(i2c_mode);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("interface choice changed");
   property p_open_drain;
      i2c_mode && miso_sda_oe |-> !miso_sda_out;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("sda driven high");
   property p_spi_drive;
      (!i2c_mode && !powered_down && !cs_n_pin)[*6] |-> miso_sda_oe;
   endproperty
   a_spi_drive: assert property (p_spi_drive) else $error("miso not driven while selected");
   property p_spi_idle;
      (!i2c_mode && cs_n_pin)[*6] |-> !miso_sda_oe;
   endproperty
   a_spi_idle: assert property (p_spi_idle) else $error("miso driven while deselected");
   property p_pd_quiet;
      s_asleep |-> !rx_valid && !frame_start && !miso_sda_oe && !backlight_en;
   endproperty
   a_pd_quiet: assert property (p_pd_quiet) else $error("link activity while powered down");
   property p_rx_pulse;
      rx_valid |=> !rx_valid;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("rx_valid longer than one cycle");
endmodule

bind dual_mode_serial_host_port serial_port_checker #(.DUTY_W(DUTY_W)) chk (
   .clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .irq_request(irq_request), .pwm_duty(pwm_duty),
   .miso_sda_out(miso_sda_out), .miso_sda_oe(miso_sda_oe), .int_n(int_n), .backlight_en(backlight_en),
   .rx_valid(rx_valid), .frame_start(frame_start), .i2c_mode(i2c_mode), .powered_down(powered_down));

// ==== tb/serial_host_model.sv ====
// host microcontroller model: spi mode 0 master and i2c master on shared pins
// assumes the bench resolves sda from pull-up, host and device pull-downs
`timescale 1ns/100ps
module serial_host_model (
   output reg  sck,
   output reg  mosi,
   output reg  cs_n,
   output reg  sda_drv,
   input  wire sda
);
   localparam H = 80; // half of the 160 ns i2c scl period, above the i2c rate ceiling; spi bits use 240 ns, under the spi one
   // idle: sck low for mode 0, deselected, lines released high
   initial begin
      {sck, mosi, cs_n, sda_drv} = 4'h7;
   end
   // straps held steady from before reset release, scl and sda idle high
   task straps(input [1:0] a);
      begin
         {cs_n, mosi, sck, sda_drv} = {a, 2'h3};
      end
   endtask
   // mode 0: data set while sck low, long low phase lets the slow answer settle
   task spi_byte(input [7:0] d, output [7:0] q);
      integer k;
      begin
         cs_n = 0;
         for (k = 7; k >= 0; k = k - 1) begin
            mosi = d[k];
            #(2 * H) sck = 1;
            q[k] = sda;
            #H sck = 0;
         end
         #H cs_n = 1;
         mosi = 1; // released, pulled up
         #H;
      end
   endtask
   // one scl clock; sda moves 20 ns after the fall so it never mimics start or stop
   task bit9(input b, output q);
      begin
         #20 sda_drv = b;
         #(H - 20) sck = 1;
         #H q = sda;
         sck = 0;
      end
   endtask
   task i2c_start;
      begin
         #20 sda_drv = 1;
         #H sck = 1;
         #H sda_drv = 0;
         #H sck = 0;
      end
   endtask
   task i2c_stop;
      begin
         #20 sda_drv = 0;
         #H sck = 1;
         #H sda_drv = 1;
         #H;
      end
   endtask
   task i2c_byte(input [7:0] d, output ack);
      integer k;
      reg     q;
      begin
         for (k = 7; k >= 0; k = k - 1) bit9(d[k], q);
         bit9(1'b1, ack); // released for the slave's acknowledge
      end
   endtask
   task i2c_read(input more, output [7:0] q);
      integer k;
      reg     n;
      begin
         for (k = 7; k >= 0; k = k - 1) bit9(1'b1, q[k]);
         bit9(~more, n); // master ack asks for another byte, nack ends the read
      end
   endtask
endmodule

// ==== tb/dual_mode_serial_host_port_tb_top.sv ====
// self-checking bench for the dual mode serial host port
// assumes the host model drives the link pins; sda is pulled up
`timescale 1ns/100ps
`include "serial_host_port_regs.vh"
module dual_mode_serial_host_port_tb_top;
   reg         clk = 0, rst = 1, mode_strap = 0, powerdown_in_n = 0, irq_request = 0, ack, pb;
   reg  [15:0] pwm_freq = 16'h1000;
   reg  [7:0]  pwm_duty = 8'h00, tx_data = 8'h00, got = 8'h00, d, q, dv;
   reg  [1:0]  a;
   wire        sck, mosi, cs_n, sda_drv, out, oe, int_n, bl, rx_valid, i2c_mode, pd, fs, fe, tt, rd;
   wire [7:0]  rx_data;
   wire        sda = (oe ? out : 1'b1) & sda_drv; // wired-and over the pull-up
   integer     err_count = 0, n_compared = 0, cyc = 0, n_rx = 0, n_fs = 0, n_fe = 0, n_tt = 0, hi, eg, i;

   serial_host_model host (.sck(sck), .mosi(mosi), .cs_n(cs_n), .sda_drv(sda_drv), .sda(sda));
   dual_mode_serial_host_port uut (
      .clk(clk), .rst(rst), .sck_scl_pin(sck), .mosi_pin(mosi), .cs_n_pin(cs_n), .miso_sda_in(sda),
      .miso_sda_out(out), .miso_sda_oe(oe), .mode_strap(mode_strap), .powerdown_in_n(powerdown_in_n),
      .int_n(int_n), .backlight_en(bl), .irq_request(irq_request), .pwm_freq(pwm_freq),
      .pwm_duty(pwm_duty), .tx_data(tx_data), .tx_taken(tt), .rx_data(rx_data), .rx_valid(rx_valid),
      .frame_start(fs), .frame_end(fe), .i2c_read(rd), .i2c_mode(i2c_mode), .powered_down(pd));

   initial begin
      forever #10 clk = ~clk;
   end
   // received bytes, frame and fetch pulse counts, and a cycle ceiling against hangs
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (rx_valid) begin
         got = rx_data;
         n_rx = n_rx + 1;
      end
      n_fs = n_fs + fs;
      n_fe = n_fe + fe;
      n_tt = n_tt + tt;
      if (cyc == 60000) begin
         err_count = err_count + 1;
         wrap_up;
      end
   end

   task tick(input integer n);
      begin
         repeat (n) @(posedge clk);
         #2;
      end
   endtask
   task check(input [7:0] seen, input [7:0] want);
      begin
         n_compared = n_compared + 1;
         if (seen !== want) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
         end
      end
   endtask
   // 7-bit address: fixed 01000, then strap bit 1, strap bit 0
   function [7:0] addr_of(input [1:0] s, input rw);
      addr_of = {`SHP_ADDR_HI, s, rw};
   endfunction
   // 2048 cycles are whole periods for these increments; high time tracks duty/128
   task pwm_run(input integer edges);
      begin
         pwm_duty = dv;
         tick(8);
         hi = 0;
         eg = 0;
         pb = bl;
         repeat (2048) begin
            tick(1);
            hi = hi + bl;
            eg = eg + (bl & ~pb);
            pb = bl;
         end
         check(hi + 256 - dv * 16 <= 512, 1'b1);
         check(eg + 1 - edges <= 2, 1'b1);
      end
   endtask
   task wrap_up;
      begin
         $display("compared %0d, mismatches %0d", n_compared, err_count);
         if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   initial begin
      i = $urandom(57448);
      tick(8);
      check(int_n, 1'b1);
      check(pd, 1'b1);
      rst = 0;
      tick(3);
      powerdown_in_n = 1;
      tick(8);
      check(pd, 1'b0);
      check(i2c_mode, 1'b0);
      irq_request = 1;
      tick(4);
      check(int_n, 1'b0);
      irq_request = 0;
      tick(4);
      check(int_n, 1'b1);
      // spi bytes: all zeros, all ones, then random
      for (i = 0; i < 6; i = i + 1) begin
         d = (i < 2) ? {8{i[0]}} : 8'($urandom);
         tx_data = 8'($urandom);
         host.spi_byte(d, q);
         tick(6);
         check(q, tx_data);
         check(got, d);
      end
      // one start and one end per frame; a byte fetched at select and after the eighth bit
      check(8'(n_fs), 8'h06);
      check(8'(n_fe), 8'h06);
      check(8'(n_tt), 8'h0C);
      // a frame while powered down leaves no trace
      powerdown_in_n = 0;
      tick(8);
      check(pd, 1'b1);
      hi = n_rx;
      host.spi_byte(8'hA5, q);
      tick(1);
      check(8'(n_rx - hi), 8'h00);
      check(8'(n_fs), 8'h06);
      powerdown_in_n = 1;
      tick(8);
      for (i = 0; i < 3; i = i + 1) begin
         pwm_freq = 16'h0800 << ($urandom % 3);
         dv = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'(8 + $urandom % 105);
         pwm_run((i < 2) ? 0 : pwm_freq / 32);
      end
      // second reset with the i2c strap and random address straps
      rst = 1;
      mode_strap = 1;
      a = 2'($urandom);
      host.straps(a);
      tick(8);
      rst = 0;
      tick(10);
      check(i2c_mode, 1'b1);
      for (i = 0; i < 3; i = i + 1) begin
         host.i2c_start;
         host.i2c_byte((i == 0) ? addr_of(a ^ 2'h1, 1'b0) : (i == 1) ? 8'h0F : addr_of(a, 1'b0), ack);
         check(ack, i < 2);
      end
      d = 8'($urandom);
      host.i2c_byte(d, ack);
      host.i2c_stop;
      check(ack, 1'b0);
      check(got, d);
      tick(1);
      check(8'(n_fs), 8'h09);
      check(8'(n_fe), 8'h07);
      check(rd, 1'b0);
      tx_data = 8'($urandom);
      host.i2c_start;
      host.i2c_byte(addr_of(a, 1'b1), ack);
      check(ack, 1'b0);
      // master ack asks for a second byte, fetched at that acknowledge
      host.i2c_read(1'b1, q);
      dv = tx_data;
      tx_data = 8'($urandom);
      check(q, dv);
      host.i2c_read(1'b0, q);
      host.i2c_stop;
      check(q, tx_data);
      check(rd, 1'b1);
      check(8'(n_tt), 8'h0E);
      wrap_up;
   end
endmodule
